/* bench/fosf_flash_model.sv */
// Behavioural flash device that answers status reads from the poller.
`timescale 1ns/10ps
module fosf_flash_model (
	input  wire logic       ce_n_i,
	input  wire logic       oe_n_i,
	input  wire logic       arm_i,
	input  wire logic [1:0] mode_i,
	input  wire logic [7:0] busy_reads_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      dq_o
);
	// Mode 0 programs, mode 1 erases, mode 2 fails on the pulse limit.
	logic [7:0] left_r;
	logic [7:0] last_r;
	logic       tog_r;
	logic       etog_r;
	logic       busy;
	logic [7:0] byte_w;
	assign busy = (mode_i == 2'h2) || (left_r != 8'h00);
	always_comb begin
		if (!busy)
			byte_w = (mode_i == 2'h0) ? data_i : 8'hff;
		else if (mode_i == 2'h0)
			byte_w = {~data_i[7], tog_r, 6'h00};
		else if (mode_i == 2'h1)
			byte_w = {1'b0, tog_r, 3'h1, etog_r, 2'h0};
		else
			byte_w = {~data_i[7], tog_r, 1'b1, 2'b00, etog_r, 2'b00};
	end
	// A completed read is marked by the output strobe returning high.
	always @(posedge oe_n_i or posedge arm_i) begin
		if (arm_i) begin
			left_r <= busy_reads_i;
			tog_r <= 1'b0;
			etog_r <= 1'b0;
		end else begin
			if (left_r != 8'h00)
				left_r <= left_r - 8'h01;
			tog_r <= ~tog_r;
			etog_r <= ~etog_r;
			last_r <= byte_w;
		end
	end
	// A released bus shows the inverse of the last value, never a stale copy.
	assign dq_o = (!ce_n_i && !oe_n_i) ? byte_w : ~last_r;
endmodule // fosf_flash_model

/* bench/test_fosf_poller.sv */
// Self-checking testbench for the flash status poller.
`timescale 1ns/10ps
module test_fosf_poller;
	import fosf_pkg::*;
	logic        clock_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        start_i = 1'b0;
	logic        read_once_i = 1'b0;
	logic        arm = 1'b0;
	logic [17:0] addr_i = '0;
	logic [1:0]  mode = 2'h0;
	logic [7:0]  nbusy = 8'h00;
	logic [7:0]  dat = 8'h00;
	logic [7:0]  dq;
	logic        busy_o, done_o, rst_need, ce_n, oe_n, we_n, dq_oe_n;
	fosf_res_t   result_o;
	logic [7:0]  status_o, dq_out;
	logic [17:0] fa;
	int          errors = 0;
	int          n_checks = 0;
	fosf_poller u_fosf_poller (.clock_i, .resetn_i, .start_i, .addr_i, .read_once_i,
		.busy_o, .done_o, .result_o, .status_o, .device_reset_needed_o(rst_need),
		.flash_addr_o(fa), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
		.flash_dq_o(dq_out), .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq));
	fosf_flash_model u_fosf_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .arm_i(arm),
		.mode_i(mode), .busy_reads_i(nbusy), .data_i(dat), .dq_o(dq));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic poll(input logic [1:0] m, input logic [7:0] n, d, input logic once);
		int i;
		mode <= m;
		nbusy <= n;
		dat <= d;
		arm <= 1'b1;
		@(posedge clock_i);
		arm <= 1'b0;
		start_i <= 1'b1;
		read_once_i <= once;
		addr_i <= {10'h000, n};
		@(posedge clock_i);
		start_i <= 1'b0;
		#1;
		for (i = 0; i < 500 && done_o !== 1'b1; i++) begin
			check({busy_o, we_n, dq_oe_n, 5'h00}, 8'he0);
			check(dq_out, 8'h00);
			check(fa[7:0], n);
			@(posedge clock_i);
			#1;
		end
		if (i == 500) begin
			errors++;
			$display("mismatch at %0t: poll never finished", $time);
			print_verdict();
		end
	endtask
	task automatic sc_program;
		poll(2'h0, 8'h06, 8'h5a, 1'b0);
		check({6'h00, result_o}, {6'h00, FOSF_RES_DONE});
		check(status_o, 8'h5a);
	endtask
	task automatic sc_erase;
		poll(2'h1, 8'h05, 8'h00, 1'b0);
		check({6'h00, result_o}, {6'h00, FOSF_RES_DONE});
		check(status_o, 8'hff);
	endtask
	task automatic sc_fail;
		poll(2'h2, 8'h03, 8'h5a, 1'b0);
		check({6'h00, result_o}, {6'h00, FOSF_RES_FAIL});
		check({7'h00, rst_need}, 8'h01);
	endtask
	task automatic sc_clear;
		poll(2'h0, 8'h02, 8'h7f, 1'b0);
		check({7'h00, rst_need}, 8'h00);
		check(status_o, 8'h7f);
	endtask
	task automatic sc_once;
		poll(2'h1, 8'h04, 8'h00, 1'b1);
		check({6'h00, result_o}, {6'h00, FOSF_RES_NONE});
		check(status_o, 8'h08);
	endtask
	initial begin
		forever #20 clock_i = ~clock_i;
	end
	initial begin
		repeat (5) @(posedge clock_i);
		#1;
		check({5'h00, ce_n, oe_n, busy_o}, 8'h06);
		check({6'h00, result_o}, {6'h00, FOSF_RES_NONE});
		@(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		sc_program();
		sc_erase();
		sc_fail();
		sc_clear();
		sc_once();
		print_verdict();
	end
endmodule // test_fosf_poller

/* hw/fosf_pkg.sv */
// Package of constants and types for the flash operation status poller.
package fosf_pkg;
	// -------------------------------------------------------------
	// Status byte bit positions
	// -------------------------------------------------------------
	localparam int COMPLETION_POLL_POS  = 7;
	localparam int TOGGLE_STATUS_POS    = 6;
	localparam int PULSE_LIMIT_POS      = 5;
	localparam int SECTOR_LOAD_POS      = 3;
	localparam int ERASING_SECTOR_POS   = 2;
	// -------------------------------------------------------------
	// Bus timing in clock cycles at 25 MHz
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS        = 40;
	localparam int READ_ACCESS_NS       = 100;
	localparam int READ_CYCLES          = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYCLES   = 2;
	localparam logic [3:0] READ_CYCLES_W = 4'(READ_CYCLES);
	localparam logic [3:0] HIGH_CYCLES_W = 4'(STROBE_HIGH_CYCLES);
	localparam logic [3:0] CNT_ZERO     = 4'h0;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [1:0] RES_POLL     = 2'h0;

	// Outcome of a status poll.
	typedef enum logic [1:0] {
		FOSF_RES_DONE,
		FOSF_RES_FAIL,
		FOSF_RES_NONE
	} fosf_res_t;

	// Poller state.
	typedef enum logic [2:0] {
		FOSF_IDLE,
		FOSF_READ,
		FOSF_GAP,
		FOSF_EVAL,
		FOSF_CONFIRM
	} fosf_state_t;
endpackage

/* hw/fosf_poller.sv */
// Host-side poller that reads flash status bytes and judges completion.
//
// Behaviour
// RULE1: Program polls true top bit when done.
// RULE2: Erase poll bit low, then high.
// RULE3: Poll at an address inside erasing sector.
// RULE4: Status valid after final write strobe.
// RULE5: Toggle bit flips while busy, settles high.
// RULE6: Done when two reads show toggle stable high.
// RULE7: Protected targets toggle briefly then return.
// RULE8: Pulse-limit flag marks failed operation.
// RULE9: After failure, reset device before continuing.
// RULE10: Programming one over zero fails.
// RULE11: Sector-load flag high closes queue window.
// RULE12: Status valid during sector-load delay.
// RULE13: Load flag low before and after accepts.
// RULE14: Status bits four, one, zero reserved.
// RULE15: Erasing-sector bit toggles in erasing sectors.
// RULE16: Failed sector reads toggle erasing-sector bit.
// RULE17: Suspend-program status at program address.
// RULE18: Poll bit may lead; confirm with reread.
// RULE19: Toggle may stop early; reread for data.
// RULE20: Keep read address stable while polling.
// RULE21: Non-suspended sector reads erasing bit high.
// RULE22: Write-strobe fall restarts load delay.
// RULE23: Device muxes status onto data pins.
// RULE24: Toggle bits flip per completed read.
`timescale 1ns/10ps
module fosf_poller #(
	parameter int ADDR_W = 18
) (
	input  wire logic                  clock_i,
	input  wire logic                  resetn_i,
	input  wire logic                  start_i,
	input  wire logic [ADDR_W-1:0]     addr_i,
	input  wire logic                  read_once_i,
	output logic                       busy_o,
	output logic                       done_o,
	output fosf_pkg::fosf_res_t        result_o,
	output logic [7:0]                 status_o,
	output logic                       device_reset_needed_o,
	output logic [ADDR_W-1:0]          flash_addr_o,
	output logic                       flash_ce_n_o,
	output logic                       flash_oe_n_o,
	output logic                       flash_we_n_o,
	output logic [7:0]                 flash_dq_o,
	output logic                       flash_dq_oe_n_o,
	input  wire logic [7:0]            flash_dq_i
);
	import fosf_pkg::*;

	fosf_state_t       state_r;
	logic [3:0]        cnt_r;
	logic [7:0]        prev_r;
	logic              have_prev_r;
	logic              once_r;
	logic [7:0]        sample_r;
	logic              tog_same;
	logic              confirm_r;
	logic              fail_r;
	logic              done_seen;
	logic              fail_seen;

	// -------------------------------------------------------------
	// Read sequencing
	// -------------------------------------------------------------
	// The address is latched once at start and held for every read.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flash_addr_o <= '0;
		end else if (state_r == FOSF_IDLE && start_i) begin
			flash_addr_o <= addr_i; // RULE20 RULE3 RULE17
		end
	end

	// The host never writes here, so data pins stay released.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flash_we_n_o    <= 1'b1;
			flash_dq_o      <= BYTE_ZERO;
			flash_dq_oe_n_o <= 1'b1;
		end else begin
			flash_we_n_o    <= 1'b1;
			flash_dq_o      <= BYTE_ZERO;
			flash_dq_oe_n_o <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r      <= FOSF_IDLE;
			cnt_r        <= CNT_ZERO;
			flash_ce_n_o <= 1'b1;
			flash_oe_n_o <= 1'b1;
			sample_r     <= BYTE_ZERO;
		end else begin
			unique case (state_r)
				FOSF_IDLE: begin
					if (start_i) begin
						state_r      <= FOSF_READ;
						cnt_r        <= READ_CYCLES_W;
						flash_ce_n_o <= 1'b0;
						flash_oe_n_o <= 1'b0;
					end
				end
				FOSF_READ: begin
					if (cnt_r == 4'h1) begin
						// Sampled at the end so the whole byte has settled.
						sample_r     <= flash_dq_i; // RULE18
						flash_ce_n_o <= 1'b1;
						flash_oe_n_o <= 1'b1; // RULE24
						state_r      <= FOSF_GAP;
						cnt_r        <= HIGH_CYCLES_W;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				FOSF_GAP: begin
					if (cnt_r == 4'h1) begin
						state_r <= FOSF_EVAL;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				FOSF_EVAL: begin
					// The confirm read ends the poll; strobes are already high here.
					if (once_r || confirm_r) begin
						state_r <= FOSF_IDLE;
					end else if (done_seen || fail_seen) begin
						state_r <= FOSF_CONFIRM; // RULE6 RULE8
					end else begin
						state_r      <= FOSF_READ;
						cnt_r        <= READ_CYCLES_W;
						flash_ce_n_o <= 1'b0;
						flash_oe_n_o <= 1'b0;
					end
				end
				FOSF_CONFIRM: begin
					// One extra read yields a fully valid byte.
					state_r      <= FOSF_READ; // RULE19
					cnt_r        <= READ_CYCLES_W;
					flash_ce_n_o <= 1'b0;
					flash_oe_n_o <= 1'b0;
				end
				default: state_r <= FOSF_IDLE;
			endcase
		end
	end

	// Toggle bit unchanged between the two latest reads.
	assign tog_same = (prev_r[TOGGLE_STATUS_POS] == sample_r[TOGGLE_STATUS_POS]); // RULE6

	// Complete when two reads show the toggle bit high and unchanged.
	assign done_seen = have_prev_r && tog_same && sample_r[TOGGLE_STATUS_POS]; // RULE6

	// Failed when the pulse-limit flag shows on two reads while toggling goes on.
	assign fail_seen = have_prev_r && !tog_same && prev_r[PULSE_LIMIT_POS]
			&& sample_r[PULSE_LIMIT_POS]; // RULE8

	// -------------------------------------------------------------
	// Judgement
	// -------------------------------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			confirm_r <= 1'b0;
		end else if (state_r == FOSF_IDLE) begin
			confirm_r <= 1'b0;
		end else if (state_r == FOSF_CONFIRM) begin
			confirm_r <= 1'b1;
		end
	end

	// The verdict is kept apart from the data bits, which may hold any array value.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fail_r <= 1'b0;
		end else if (state_r == FOSF_IDLE && start_i) begin
			fail_r <= 1'b0;
		end else if (state_r == FOSF_EVAL && !once_r && !confirm_r && fail_seen) begin
			fail_r <= 1'b1; // RULE8 RULE10
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_r      <= BYTE_ZERO;
			have_prev_r <= 1'b0;
			once_r      <= 1'b0;
		end else if (state_r == FOSF_IDLE && start_i) begin
			have_prev_r <= 1'b0;
			once_r      <= read_once_i;
		end else if (state_r == FOSF_EVAL) begin
			prev_r      <= sample_r;
			have_prev_r <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_o                <= 1'b0;
			done_o                <= 1'b0;
			result_o              <= FOSF_RES_NONE;
			status_o              <= BYTE_ZERO;
			device_reset_needed_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (state_r == FOSF_IDLE && start_i) begin
				busy_o <= 1'b1;
			end
			if (state_r == FOSF_EVAL && (once_r || confirm_r)) begin
				busy_o   <= 1'b0;
				done_o   <= 1'b1;
				// Reserved bits are reported as read; only named bits are judged.
				status_o <= sample_r; // RULE14
				if (once_r) begin
					result_o <= FOSF_RES_NONE;
				end else if (fail_r) begin
					result_o              <= FOSF_RES_FAIL; // RULE8 RULE10
					device_reset_needed_o <= 1'b1; // RULE9
				end else begin
					result_o <= FOSF_RES_DONE; // RULE1 RULE2 RULE5
				end
			end
			if (state_r == FOSF_IDLE && start_i && !read_once_i) begin
				device_reset_needed_o <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	stable_addr_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(busy_o && state_r != FOSF_IDLE) |=> $stable(flash_addr_o)) // RULE20
		else $error("address moved while polling");
	no_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		flash_we_n_o && flash_dq_oe_n_o) // RULE4
		else $error("poller drove a write");
	fail_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(done_o && result_o == FOSF_RES_FAIL) |-> device_reset_needed_o) // RULE9
		else $error("failure without reset request");
	read_len_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		$fell(flash_oe_n_o) |-> !flash_oe_n_o [*3]) // RULE24
		else $error("read strobe too short");
	done_pulse_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		done_o |=> !done_o) // RULE6
		else $error("done longer than a cycle");
	done_idle_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		done_o |-> !busy_o) // RULE19
		else $error("done while busy");
	ok_stable_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(done_o && result_o == FOSF_RES_DONE) |-> status_o[TOGGLE_STATUS_POS]) // RULE5
		else $error("done with toggle low");
	ce_oe_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		flash_ce_n_o == flash_oe_n_o) // RULE18
		else $error("strobes split");
endmodule // fosf_poller
